// [csw_top.sv]
// Behaviour
// - Flag fault when on-time exceeds period
// - Misconfigured sole cyclic sense sends sleep to restart
// - Sample wake input once at on-phase end
// - Cyclic sense wake sets input wake flag
// - Level status takes only sampled levels during cyclic sense
// - Level change interrupts, or powers regulator in sleep
// - Wake fires even if flag already set
// - Fail-safe disables switch, senses statically
// - Switch faults disable that high-side switch
// - Stop wake interrupts, sleep wake restarts
// - Uncleared flags at sleep cause immediate restart
// - Cyclic wake interrupts, or restarts from sleep
// - On-time field alone enables each timer
// - Cyclic wake starts on on-time write
// - Interrupt each on-start except the first
// - Two independent timers, mapped by high-side control
// - Cyclic sense starts on on-time write
`timescale 1ns/1ns
`default_nettype none
module csw_top
   import csw_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic              i_wr_en,
   input  wire logic              i_rd_en,
   output logic      [DATA_W-1:0] o_rd_data,
   input  wire logic [NUM_HS-1:0] i_wake_input,
   input  wire logic [NUM_HS-1:0] i_hs_fault,
   input  wire logic              i_bridge_short_wake,
   input  wire logic              i_fail_safe_event,
   output logic      [NUM_HS-1:0] o_high_side_output,
   output logic                   o_interrupt_out_n,
   output logic                   o_reset_out_n,
   output logic                   o_main_regulator_en,
   output logic      [4:0]        o_mode
);

   csw_mode_t             mode_reg;
   csw_mode_t             mode_next;
   logic [TICKDIV_W-1:0]  tdiv_reg;
   logic                  tick;
   logic [RSTCNT_W-1:0]   rst_cnt_reg;
   logic [TCTRL_W-1:0]    tmr_ctrl_reg [NUM_TMR];
   logic [2*NUM_HS-1:0]   hs_sel_reg;
   logic [2*NUM_HS-1:0]   hs_sel_next;
   logic [NUM_HS-1:0]     wake_en_reg;
   logic [NUM_TMR-1:0]    cyc_wake_reg;
   logic [NUM_HS-1:0]     wake_flag_reg;
   logic [NUM_TMR-1:0]    tmr_flag_reg;
   logic                  bridge_flag_reg;
   logic [NUM_HS-1:0]     level_reg;
   logic [NUM_HS-1:0]     level_next;
   logic                  spi_fail_reg;
   logic [NUM_HS-1:0]     hs_out_reg;
   logic [NUM_HS-1:0]     hs_out_next;
   logic                  int_n_reg;
   logic [DATA_W-1:0]     rd_data_reg;

   logic [NUM_TMR-1:0]    wr_tmr;
   logic [NUM_TMR-1:0]    tmr_valid;
   logic [NUM_TMR-1:0]    tmr_ok;
   logic [NUM_TMR-1:0]    tmr_bad;
   logic [NUM_TMR-1:0]    tmr_on;
   logic [NUM_TMR-1:0]    tmr_start;
   logic [NUM_TMR-1:0]    tmr_sample;
   logic [NUM_TMR-1:0]    tmr_wake;
   logic [NUM_HS-1:0]     cs_active;
   logic [NUM_HS-1:0]     cs_ok;
   logic [NUM_HS-1:0]     strobe;
   logic [NUM_HS-1:0]     wake_evt;

   // Register decode
   wire cfg_ok    = (mode_reg == CSW_NORMAL);
   wire wr_hs     = i_wr_en && cfg_ok && (i_addr == ADDR_HIGH_SIDE_CONTROL_REG);
   wire wr_wake   = i_wr_en && cfg_ok && (i_addr == ADDR_WAKE_CTRL);
   wire wr_stat   = i_wr_en && (i_addr == ADDR_WAKE_STAT);
   wire wr_bridge = i_wr_en && (i_addr == ADDR_BRIDGE_STAT);
   wire wr_mode   = i_wr_en && (i_addr == ADDR_MODE);
   wire [1:0] cmd = i_wr_data[MODE_CMD_LSB +: 2];

   wire sleep_req  = wr_mode && (mode_reg == CSW_NORMAL) && (cmd == MODE_CMD_SLEEP);
   wire stop_req   = wr_mode && (mode_reg == CSW_NORMAL) && (cmd == MODE_CMD_STOP);
   wire normal_req = wr_mode && (mode_reg == CSW_STOP) && (cmd == MODE_CMD_NORMAL);

   wire sensing = (mode_reg == CSW_NORMAL) || (mode_reg == CSW_STOP) ||
                  (mode_reg == CSW_SLEEP);
   wire awake   = (mode_reg == CSW_NORMAL) || (mode_reg == CSW_STOP);

   wire flags_dirty = (|wake_flag_reg) || (|tmr_flag_reg) || bridge_flag_reg;
   wire valid_src   = (|(wake_en_reg & ~cs_active)) || (|(wake_en_reg & cs_ok)) ||
                      (|(cyc_wake_reg & tmr_valid));
   wire any_wake    = (|wake_evt) || (|tmr_wake) || i_bridge_short_wake;
   wire dis_entry   = ((mode_next == CSW_RESTART) || (mode_next == CSW_FAILSAFE)) &&
                      (mode_next != mode_reg);
   wire rst_done    = (rst_cnt_reg == RSTCNT_W'(RESTART_CYCLES - 1));

   wire [NUM_HS-1:0]  wake_clr = wr_stat ? i_wr_data[WAKE_EN_LSB +: NUM_HS] : 3'h0;
   wire [NUM_TMR-1:0] tmr_clr  = wr_stat ? i_wr_data[STAT_TMR_LSB +: NUM_TMR] : 2'h0;
   wire               fail_clr = wr_mode && i_wr_data[MODE_FAULT_BIT];

   // Low-frequency tick
   assign tick = (tdiv_reg == TICKDIV_W'(TICK_CYCLES - 1));

   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         CSW_NORMAL:
         begin
            if (sleep_req)
               mode_next = (flags_dirty || !valid_src) ? CSW_RESTART : CSW_SLEEP;
            else if (stop_req)
               mode_next = CSW_STOP;
         end
         CSW_STOP:
         begin
            if (normal_req)
               mode_next = CSW_NORMAL;
         end
         CSW_SLEEP:
         begin
            if (any_wake)
               mode_next = CSW_RESTART;
         end
         CSW_RESTART:
         begin
            if (rst_done)
               mode_next = CSW_NORMAL;
         end
         CSW_FAILSAFE:
         begin
            if (any_wake)
               mode_next = CSW_RESTART;
         end
         default:
            mode_next = CSW_NORMAL;
      endcase
      if (i_fail_safe_event)
         mode_next = CSW_FAILSAFE;
   end

   genvar t;
   generate
      for (t = 0; t < NUM_TMR; t++)
      begin : g_tmr
         wire [TCNT_W-1:0] on_t  = csw_on_ticks(tmr_ctrl_reg[t][TMR_ON_LSB +: 3]);
         wire [TCNT_W-1:0] per_t = csw_per_ticks(tmr_ctrl_reg[t][TMR_PER_LSB +: 3]);
         // Timer restarts with the value being written, not the old one
         wire [TCTRL_W-1:0] ctrl_next  = dis_entry ? TMR_CTRL_RST :
                                         wr_tmr[t] ? i_wr_data[TCTRL_W-1:0] : tmr_ctrl_reg[t];
         wire [TCNT_W-1:0]  on_t_next  = csw_on_ticks(ctrl_next[TMR_ON_LSB +: 3]);
         wire [TCNT_W-1:0]  per_t_next = csw_per_ticks(ctrl_next[TMR_PER_LSB +: 3]);
         assign wr_tmr[t]    = i_wr_en && cfg_ok &&
                               (i_addr == ADDR_TIMER1 + ADDR_W'(t) * ADDR_TIMER_STEP);
         assign tmr_valid[t] = (on_t != 12'h000);
         assign tmr_bad[t]   = tmr_valid[t] && (on_t > per_t);
         assign tmr_ok[t]    = tmr_valid[t] && !tmr_bad[t];
         assign tmr_wake[t]  = tmr_start[t] && cyc_wake_reg[t];

         always_ff @(posedge i_clk)
         begin
            if (!i_rst_n)
               tmr_ctrl_reg[t] <= TMR_CTRL_RST;
            else if (dis_entry)
               tmr_ctrl_reg[t] <= TMR_CTRL_RST;
            else if (wr_tmr[t])
               tmr_ctrl_reg[t] <= i_wr_data[TCTRL_W-1:0];
         end

         // Independent timer per index
         csw_timer u_timer (
            .i_clk          (i_clk),
            .i_rst_n        (i_rst_n),
            .i_tick         (tick),
            .i_restart      (wr_tmr[t] || dis_entry),
            .i_valid        (on_t_next != 12'h000),
            .i_on_ticks     (on_t_next),
            .i_per_ticks    (per_t_next),
            .o_on_phase     (tmr_on[t]),
            .o_start_pulse  (tmr_start[t]),
            .o_sample_pulse (tmr_sample[t])
         );
      end
   endgenerate

   genvar c;
   generate
      for (c = 0; c < NUM_HS; c++)
      begin : g_ch
         wire [1:0] sel     = hs_sel_reg[2*c +: 2];
         wire       tsel    = sel[0];
         wire       changed = (i_wake_input[c] != level_reg[c]);
         assign cs_active[c] = sensing && sel[1] && tmr_valid[tsel];
         assign cs_ok[c]     = cs_active[c] && tmr_ok[tsel];
         assign strobe[c]    = cs_active[c] && tmr_sample[tsel];
         // Static sensing whenever cyclic sense is not running
         assign wake_evt[c]  = changed && (strobe[c] ||
                               (wake_en_reg[c] && !cs_active[c]));
         assign level_next[c] = (strobe[c] || !cs_active[c]) ? i_wake_input[c] :
                                level_reg[c];
         assign hs_sel_next[2*c +: 2] =
            dis_entry                   ? HS_OFF :
            (i_hs_fault[c] && sensing)  ? HS_OFF :
            wr_hs                       ? i_wr_data[2*c +: 2] : sel;
         assign hs_out_next[c] = (sel == HS_ON) ||
                                 (((sel == HS_TMR1) || (sel == HS_TMR2)) && tmr_on[tsel]);
      end
   endgenerate

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         mode_reg    <= CSW_NORMAL;
         tdiv_reg    <= '0;
         rst_cnt_reg <= '0;
         hs_sel_reg  <= HIGH_SIDE_CONTROL_REG_RST;
         hs_out_reg  <= '0;
         level_reg   <= '0;
      end
      else
      begin
         mode_reg    <= mode_next;
         tdiv_reg    <= tick ? '0 : tdiv_reg + TICKDIV_W'(1);
         rst_cnt_reg <= (mode_reg == CSW_RESTART) ? rst_cnt_reg + RSTCNT_W'(1) : '0;
         hs_sel_reg  <= hs_sel_next;
         hs_out_reg  <= hs_out_next;
         level_reg   <= level_next;
      end
   end

   // Sticky flags, a new event beats the clear
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         wake_en_reg     <= WAKE_EN_RST;
         cyc_wake_reg    <= CYC_WAKE_RST;
         wake_flag_reg   <= '0;
         tmr_flag_reg    <= '0;
         bridge_flag_reg <= 1'b0;
         spi_fail_reg    <= 1'b0;
         int_n_reg       <= 1'b1;
      end
      else
      begin
         if (wr_wake)
         begin
            wake_en_reg  <= i_wr_data[WAKE_EN_LSB +: NUM_HS];
            cyc_wake_reg <= i_wr_data[CYC_WAKE_LSB +: NUM_TMR];
         end
         wake_flag_reg   <= (wake_flag_reg & ~wake_clr) | wake_evt;
         tmr_flag_reg    <= (tmr_flag_reg & ~tmr_clr) | tmr_wake;
         bridge_flag_reg <= (bridge_flag_reg && !(wr_bridge && i_wr_data[0])) ||
                            i_bridge_short_wake;
         spi_fail_reg    <= (spi_fail_reg && !fail_clr) || (|tmr_bad) ||
                            (sleep_req && !valid_src);
         int_n_reg       <= !(any_wake && awake);
      end
   end

   // Read port
   wire [DATA_W-1:0] rd_val =
      (i_addr == ADDR_TIMER1)                   ? DATA_W'(tmr_ctrl_reg[0]) :
      (i_addr == ADDR_TIMER1 + ADDR_TIMER_STEP) ? DATA_W'(tmr_ctrl_reg[1]) :
      (i_addr == ADDR_HIGH_SIDE_CONTROL_REG)                  ? DATA_W'(hs_sel_reg) :
      (i_addr == ADDR_WAKE_CTRL)                ? (DATA_W'(wake_en_reg) |
                                                   (DATA_W'(cyc_wake_reg) << CYC_WAKE_LSB)) :
      (i_addr == ADDR_WAKE_STAT)                ? (DATA_W'(wake_flag_reg) |
                                                   (DATA_W'(tmr_flag_reg) << STAT_TMR_LSB)) :
      (i_addr == ADDR_LEVEL_STAT)               ? DATA_W'(level_reg) :
      (i_addr == ADDR_BRIDGE_STAT)              ? DATA_W'(bridge_flag_reg) :
      (i_addr == ADDR_MODE)                     ? ((DATA_W'(spi_fail_reg) << MODE_FAULT_BIT) |
                                                   (DATA_W'(mode_reg) << MODE_STATE_LSB)) :
      32'h0000_0000;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         rd_data_reg <= '0;
      else if (i_rd_en)
         rd_data_reg <= rd_val;
      else
         rd_data_reg <= '0;
   end

   assign o_rd_data           = rd_data_reg;
   assign o_high_side_output  = hs_out_reg;
   assign o_interrupt_out_n   = int_n_reg;
   assign o_reset_out_n       = !((mode_reg == CSW_SLEEP) || (mode_reg == CSW_RESTART));
   assign o_main_regulator_en = !((mode_reg == CSW_SLEEP) || (mode_reg == CSW_FAILSAFE));
   assign o_mode              = mode_reg;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   fault_flag_a: assert property ((|tmr_bad) |=> spi_fail_reg)
      else $error("fault flag not set for long on-time");
   sole_source_a: assert property (sleep_req && !valid_src && !i_fail_safe_event |=>
      mode_reg == CSW_RESTART && spi_fail_reg)
      else $error("sleep without wake source not restarted");
   sample_once_a: assert property (tmr_sample[0] |-> !tmr_on[0] && $past(tmr_on[0]))
      else $error("sample not at on-phase end");
   sample_flag_a: assert property (strobe[0] && (i_wake_input[0] != level_reg[0]) |=>
      wake_flag_reg[0] && level_reg[0] == $past(i_wake_input[0]))
      else $error("sampled change lost");
   level_hold_a: assert property (cs_active[0] && !strobe[0] |=>
      level_reg[0] == $past(level_reg[0]))
      else $error("level status followed pin during cyclic sense");
   awake_int_a: assert property (any_wake && awake |=> !o_interrupt_out_n)
      else $error("wake in normal or stop gave no interrupt");
   sleep_wake_a: assert property (mode_reg == CSW_SLEEP && any_wake && !i_fail_safe_event |=>
      mode_reg == CSW_RESTART && !o_reset_out_n && o_main_regulator_en ##RESTART_CYCLES
      mode_reg == CSW_NORMAL)
      else $error("sleep wake did not pass restart to normal");
   dirty_sleep_a: assert property (sleep_req && flags_dirty && !i_fail_safe_event |=>
      mode_reg == CSW_RESTART && !o_reset_out_n)
      else $error("sleep with uncleared flags not refused");
   fs_hs_off_a: assert property ($rose(mode_reg == CSW_FAILSAFE) |->
      hs_sel_reg == '0 ##1 o_high_side_output == '0)
      else $error("high side still on in fail-safe");
   hs_fault_a: assert property (i_hs_fault[0] && sensing |=> hs_sel_reg[1:0] == HS_OFF)
      else $error("faulted switch not disabled");
   first_start_a: assert property (wr_tmr[0] |=> !tmr_start[0] && tmr_on[0] == tmr_valid[0])
      else $error("first on-time raised start or on-phase missing");

   cs_wake_c: cover property (mode_reg == CSW_SLEEP && (|(strobe & wake_evt)));
   cyc_wake_c: cover property (awake && (|tmr_wake) ##1 !o_interrupt_out_n);
   fs_entry_c: cover property (mode_reg == CSW_FAILSAFE && (|wake_evt));

endmodule
`default_nettype wire

// [csw_pkg.sv]
`default_nettype none
package csw_pkg;

   localparam int CLK_PERIOD_NS   = 50;
   localparam int TICK_TIME_NS    = 100000;
   localparam int TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int RESTART_TIME_NS = 10000;
   localparam int RESTART_CYCLES  = (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int NUM_HS    = 3;
   localparam int NUM_TMR   = 2;
   localparam int TCNT_W    = 12;
   localparam int TICKDIV_W = 12;
   localparam int RSTCNT_W  = 8;
   localparam int TCTRL_W   = 7;

   localparam logic [ADDR_W-1:0] ADDR_TIMER1      = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_TIMER_STEP  = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_HIGH_SIDE_CONTROL_REG     = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_WAKE_CTRL   = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_WAKE_STAT   = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_LEVEL_STAT  = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_BRIDGE_STAT = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_MODE        = 8'h1c;

   localparam int TMR_ON_LSB     = 0;
   localparam int TMR_PER_LSB    = 4;
   localparam int WAKE_EN_LSB    = 0;
   localparam int CYC_WAKE_LSB   = 4;
   localparam int STAT_TMR_LSB   = 4;
   localparam int MODE_CMD_LSB   = 0;
   localparam int MODE_FAULT_BIT = 8;
   localparam int MODE_STATE_LSB = 16;

   localparam logic [TCTRL_W-1:0]   TMR_CTRL_RST = 7'h00;
   localparam logic [2*NUM_HS-1:0]  HIGH_SIDE_CONTROL_REG_RST  = 6'h00;
   localparam logic [NUM_HS-1:0]    WAKE_EN_RST  = 3'h0;
   localparam logic [NUM_TMR-1:0]   CYC_WAKE_RST = 2'h0;

   localparam logic [1:0] HS_OFF  = 2'h0;
   localparam logic [1:0] HS_ON   = 2'h1;
   localparam logic [1:0] HS_TMR1 = 2'h2;
   localparam logic [1:0] HS_TMR2 = 2'h3;

   localparam logic [1:0] MODE_CMD_NORMAL = 2'h1;
   localparam logic [1:0] MODE_CMD_STOP   = 2'h2;
   localparam logic [1:0] MODE_CMD_SLEEP  = 2'h3;

   typedef enum logic [4:0] {
      CSW_NORMAL   = 5'h01,
      CSW_STOP     = 5'h02,
      CSW_SLEEP    = 5'h04,
      CSW_RESTART  = 5'h08,
      CSW_FAILSAFE = 5'h10
   } csw_mode_t;

   // On-time codes in ticks; 000, 110 and 111 switch the timer off
   function automatic logic [TCNT_W-1:0] csw_on_ticks(input logic [2:0] code);
      case (code)
         3'h1:    csw_on_ticks = 12'h001;
         3'h2:    csw_on_ticks = 12'h003;
         3'h3:    csw_on_ticks = 12'h00a;
         3'h4:    csw_on_ticks = 12'h014;
         3'h5:    csw_on_ticks = 12'h032;
         default: csw_on_ticks = 12'h000;
      endcase
   endfunction

   // Period codes in ticks
   function automatic logic [TCNT_W-1:0] csw_per_ticks(input logic [2:0] code);
      case (code)
         3'h0:    csw_per_ticks = 12'h00a;
         3'h1:    csw_per_ticks = 12'h014;
         3'h2:    csw_per_ticks = 12'h032;
         3'h3:    csw_per_ticks = 12'h064;
         3'h4:    csw_per_ticks = 12'h0c8;
         3'h5:    csw_per_ticks = 12'h1f4;
         3'h6:    csw_per_ticks = 12'h3e8;
         default: csw_per_ticks = 12'h7d0;
      endcase
   endfunction

endpackage
`default_nettype wire

// [csw_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module csw_timer
   import csw_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_tick,
   input  wire logic              i_restart,
   input  wire logic              i_valid,
   input  wire logic [TCNT_W-1:0] i_on_ticks,
   input  wire logic [TCNT_W-1:0] i_per_ticks,
   output logic                   o_on_phase,
   output logic                   o_start_pulse,
   output logic                   o_sample_pulse
);

   logic [TCNT_W-1:0] cnt_reg;
   logic [TCNT_W-1:0] cnt_next;
   logic              on_reg;
   logic              on_next;
   logic              start_reg;
   logic              sample_reg;

   wire [TCNT_W-1:0] cnt_inc  = cnt_reg + 12'h001;
   wire              run_tick = i_tick && i_valid && !i_restart;
   wire              wrap     = run_tick && (cnt_inc == i_per_ticks);
   wire              on_end   = run_tick && !wrap && on_reg && (cnt_inc == i_on_ticks);

   // Restart on rewrite, on-phase opens every period start
   assign cnt_next = (i_restart || !i_valid) ? 12'h000 :
                     wrap                    ? 12'h000 :
                     run_tick                ? cnt_inc : cnt_reg;
   assign on_next  = i_restart ? i_valid :
                     !i_valid  ? 1'b0    :
                     wrap      ? 1'b1    :
                     on_end    ? 1'b0    : on_reg;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         cnt_reg    <= 12'h000;
         on_reg     <= 1'b0;
         start_reg  <= 1'b0;
         sample_reg <= 1'b0;
      end
      else
      begin
         cnt_reg    <= cnt_next;
         on_reg     <= on_next;
         start_reg  <= wrap;
         sample_reg <= on_end;
      end
   end

   assign o_on_phase     = on_reg;
   assign o_start_pulse  = start_reg;
   assign o_sample_pulse = sample_reg;

endmodule
`default_nettype wire

// [csw_wake_circuit.sv]
`timescale 1ns/1ns
`default_nettype none
module csw_wake_circuit
   import csw_pkg::*;
(
   input  wire logic [NUM_HS-1:0] i_high_side_output,
   input  wire logic [NUM_HS-1:0] i_switch_closed,
   input  wire logic [NUM_HS-1:0] i_direct_level,
   output logic      [NUM_HS-1:0] o_wake_input
);
   // Switch fed by the high side, pulled down when unpowered or open
   assign o_wake_input = (i_high_side_output & i_switch_closed) | i_direct_level;
endmodule
`default_nettype wire

// [cyclic_sense_wake_timers_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module cyclic_sense_wake_timers_tb
   import csw_pkg::*;
;
   logic              i_clk = 1'b0;
   logic              i_rst_n = 1'b0;
   logic [ADDR_W-1:0] i_addr = 8'h00;
   logic [DATA_W-1:0] i_wr_data = 32'h0;
   logic              i_wr_en = 1'b0;
   logic              i_rd_en = 1'b0;
   logic [DATA_W-1:0] o_rd_data;
   logic [NUM_HS-1:0] wake_pin;
   logic [NUM_HS-1:0] hs_fault = 3'h0;
   logic              fail_safe = 1'b0;
   logic              bridge_wake = 1'b0;
   logic [NUM_HS-1:0] hs_out;
   logic [NUM_HS-1:0] sw_closed = 3'h0;
   logic              int_n;
   logic              rst_out_n;
   logic              reg_en;
   logic [4:0]        mode;
   int                err_total = 0;
   int                total_checks = 0;
   int                cyc = 0;
   int                n;

   always #25 i_clk = ~i_clk;

   csw_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
      .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_wake_input(wake_pin),
      .i_hs_fault(hs_fault), .i_bridge_short_wake(bridge_wake), .i_fail_safe_event(fail_safe),
      .o_high_side_output(hs_out), .o_interrupt_out_n(int_n), .o_reset_out_n(rst_out_n),
      .o_main_regulator_en(reg_en), .o_mode(mode));

   csw_wake_circuit partner (.i_high_side_output(hs_out), .i_switch_closed(sw_closed),
      .i_direct_level(3'h0), .o_wake_input(wake_pin));

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         err_total++;
         test_done();
      end
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_en <= 1'b1;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      #1;
      `CHK(o_rd_data, e)
   endtask

   // Cycles until the interrupt pulse, or max when none comes
   task automatic wait_int(input int max, output int cnt);
      for (cnt = 0; cnt < max; cnt++)
      begin
         @(posedge i_clk);
         #1;
         if (int_n === 1'b0)
            break;
      end
   endtask

   task automatic wait_mode(input logic [4:0] m, input int max);
      for (int k = 0; k < max && mode !== m; k++)
         @(posedge i_clk);
      #1;
      `CHK(mode, m)
   endtask

   initial
   begin
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(ADDR_MODE, 32'h00010000);
      rd(8'h20, 32'h0);
      `CHK({rst_out_n, reg_en, int_n, hs_out}, 6'h38)
      // Fault flag for on-time beyond period
      wr(ADDR_TIMER1, 32'h05);
      rd(ADDR_MODE, 32'h00010100);
      wr(ADDR_TIMER1, 32'h0);
      wr(ADDR_MODE, 32'h100);
      rd(ADDR_MODE, 32'h00010000);
      // On codes as enable, timer 2 mapped to switch 1
      wr(ADDR_HIGH_SIDE_CONTROL_REG, 32'h0c);
      for (int c = 0; c < 8; c++)
      begin
         wr(ADDR_TIMER_STEP, c);
         repeat (3) @(posedge i_clk);
         `CHK(hs_out[1], (c >= 1 && c <= 5))
      end
      wr(ADDR_TIMER_STEP, 32'h0);
      wr(ADDR_MODE, 32'h100);
      // Switch fault drops the switch
      wr(ADDR_HIGH_SIDE_CONTROL_REG, 32'h01);
      repeat (3) @(posedge i_clk);
      `CHK(hs_out[0], 1'b1)
      hs_fault <= 3'h1;
      @(posedge i_clk);
      hs_fault <= 3'h0;
      repeat (3) @(posedge i_clk);
      `CHK(hs_out[0], 1'b0)
      rd(ADDR_HIGH_SIDE_CONTROL_REG, 32'h0);
      // Cyclic sense: level, mapping, wake pin, then timer; 0.1 ms on-time
      sw_closed <= 3'h1;
      wr(ADDR_HIGH_SIDE_CONTROL_REG, 32'h02);
      wr(ADDR_WAKE_CTRL, 32'h01);
      wr(ADDR_TIMER1, 32'h01);
      wait_int(TICK_CYCLES + 200, n);
      `CHK((n > TICK_CYCLES - 100 && n < TICK_CYCLES + 200), 1'b1)
      rd(ADDR_WAKE_STAT, 32'h1);
      rd(ADDR_LEVEL_STAT, 32'h1);
      sw_closed <= 3'h0;
      wait_int(10 * TICK_CYCLES + 500, n);
      `CHK((n > 8 * TICK_CYCLES && n < 10 * TICK_CYCLES + 500), 1'b1)
      rd(ADDR_LEVEL_STAT, 32'h0);
      // Sleep with a flag still set
      wr(ADDR_MODE, {30'h0, MODE_CMD_SLEEP});
      repeat (2) @(posedge i_clk);
      `CHK({mode, rst_out_n}, {CSW_RESTART, 1'b0})
      wait_mode(CSW_NORMAL, RESTART_CYCLES + 10);
      `CHK(rst_out_n, 1'b1)
      // Sole cyclic sense without wake enable
      wr(ADDR_WAKE_STAT, 32'h3f);
      wr(ADDR_WAKE_CTRL, 32'h0);
      wr(ADDR_HIGH_SIDE_CONTROL_REG, 32'h02);
      wr(ADDR_TIMER1, 32'h01);
      wr(ADDR_MODE, {30'h0, MODE_CMD_SLEEP});
      rd(ADDR_MODE, 32'h00080100);
      wait_mode(CSW_NORMAL, RESTART_CYCLES + 10);
      wr(ADDR_MODE, 32'h100);
      // Cyclic wake on timer 2: no interrupt at the first start
      wr(ADDR_WAKE_STAT, 32'h3f);
      wr(ADDR_WAKE_CTRL, 32'h20);
      wr(ADDR_TIMER_STEP, 32'h01);
      wait_int(10 * TICK_CYCLES + 500, n);
      `CHK((n > 9 * TICK_CYCLES && n < 10 * TICK_CYCLES + 500), 1'b1)
      rd(ADDR_WAKE_STAT, 32'h20);
      wr(ADDR_WAKE_STAT, 32'h20);
      wr(ADDR_MODE, {30'h0, MODE_CMD_SLEEP});
      repeat (2) @(posedge i_clk);
      `CHK({mode, reg_en}, {CSW_SLEEP, 1'b0})
      wait_mode(CSW_RESTART, 10 * TICK_CYCLES + 500);
      `CHK(reg_en, 1'b1)
      wait_mode(CSW_NORMAL, RESTART_CYCLES + 10);
      // Stop mode: config refused, bridge wake interrupts
      wr(ADDR_MODE, {30'h0, MODE_CMD_STOP});
      wr(ADDR_HIGH_SIDE_CONTROL_REG, 32'h01);
      rd(ADDR_HIGH_SIDE_CONTROL_REG, 32'h0);
      @(posedge i_clk);
      bridge_wake <= 1'b1;
      @(posedge i_clk);
      bridge_wake <= 1'b0;
      #1;
      `CHK({mode, int_n}, {CSW_STOP, 1'b0})
      rd(ADDR_BRIDGE_STAT, 32'h1);
      wr(ADDR_BRIDGE_STAT, 32'h1);
      rd(ADDR_BRIDGE_STAT, 32'h0);
      wr(ADDR_MODE, {30'h0, MODE_CMD_NORMAL});
      rd(ADDR_MODE, 32'h00010000);
      // Fail-safe drops the switch and the regulator
      wr(ADDR_HIGH_SIDE_CONTROL_REG, 32'h01);
      fail_safe <= 1'b1;
      repeat (3) @(posedge i_clk);
      `CHK({mode, hs_out, reg_en}, {CSW_FAILSAFE, 3'h0, 1'b0})
      test_done();
   end
endmodule
`default_nettype wire
